// File: hw/lec_pkg.sv
// Constants, field layout and carrier types for the lookup engine control register.
// Assumes a single 200 MHz switch core clock with a synchronous active-high reset.
package lec_pkg;

    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 10;
    localparam int          MAC_W           = 48;

    localparam logic [11:0] LFC_OFFSET      = 12'h310;

    localparam int          VLAN_EN_BIT     = 7;
    localparam int          DROP_VID_BIT    = 6;
    localparam int          AGE_LSB         = 3;
    localparam int          AGE_MSB         = 5;
    localparam int          RMC_EN_BIT      = 2;
    localparam int          HASH_LSB        = 0;
    localparam int          HASH_MSB        = 1;

    localparam logic [7:0]  LFC_RESET       = 8'h61;
    localparam logic [9:0]  CRC_POLY        = 10'h233;

    typedef enum logic [1:0] {
        LEC_HASH_DIRECT = 2'b00,
        LEC_HASH_CRC    = 2'b01,
        LEC_HASH_XOR    = 2'b10,
        LEC_HASH_DIR2   = 2'b11
    } lec_hash_t;

    typedef enum logic [1:0] {
        LEC_VID_PASS    = 2'b00,
        LEC_VID_DROP    = 2'b01,
        LEC_VID_HOST    = 2'b10,
        LEC_VID_UNKNOWN = 2'b11
    } lec_vid_action_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [11:0]       address;
        logic [3:0]        byteenable;
        logic [31:0]       writedata;
    } lec_avm_req_t;

    typedef struct packed {
        logic              valid;
        logic [47:0]       dest_mac;
    } lec_hash_req_t;

    typedef struct packed {
        logic              valid;
        logic [9:0]        index;
    } lec_hash_rsp_t;

    typedef struct packed {
        logic              valid;
        logic              vid_invalid;
        logic              unknown_vid_fwd_en;
        logic              rmc_match;
    } lec_frame_req_t;

    typedef struct packed {
        logic              valid;
        lec_vid_action_t   vid_action;
        logic              rmc_hit;
    } lec_frame_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [2:0]        age_count;
    } lec_age_rsp_t;

endpackage

// File: hw/lec_lookup_config.sv
// Lookup engine control register: one 8-bit configuration word on Avalon-MM plus
// the small decision paths it steers (VLAN, invalid VID, aging, reserved multicast, hash).
// Assumes requests on the frame, entry and hash ports come from logic on sys_clk.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module lec_lookup_config (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire lec_pkg::lec_avm_req_t  avm_req,
    output logic [31:0]                 avm_readdata,
    output logic                        avm_readdatavalid,
    output logic                        avm_waitrequest,
    output logic                        vlan_mode_en,
    output logic                        rmc_lookup_en,
    output lec_pkg::lec_hash_t          lookup_index_hash_select,
    input  wire lec_pkg::lec_frame_req_t frame_req,
    output lec_pkg::lec_frame_rsp_t     frame_rsp,
    input  wire logic                   entry_update,
    output lec_pkg::lec_age_rsp_t       entry_age,
    input  wire lec_pkg::lec_hash_req_t hash_req,
    output lec_pkg::lec_hash_rsp_t      hash_rsp
);

    typedef struct packed {
        logic [7:0]               cfg;
        logic                     ack;
        logic [31:0]              rdata;
        logic                     rvalid;
        lec_pkg::lec_frame_rsp_t  frame;
        lec_pkg::lec_age_rsp_t    age;
        lec_pkg::lec_hash_rsp_t   hash;
    } lec_state_t;

    lec_state_t state_reg;
    lec_state_t state_next;

    logic                       hit;
    logic                       req;
    lec_pkg::lec_hash_t         hsel;
    logic [9:0]                 crc_idx;
    logic [9:0]                 xor_idx;

    // Serial CRC over the destination address, most significant bit first.
    function automatic logic [9:0] lec_crc10(input logic [47:0] mac);
        logic [9:0] crc;
        logic       fb;
        crc = 10'h3ff;
        for (int i = 47; i >= 0; i--) begin
            fb  = crc[9] ^ mac[i];
            crc = {crc[8:0], 1'b0};
            if (fb) begin
                crc = crc ^ lec_pkg::CRC_POLY;
            end
        end
        return crc;
    endfunction

    // Folds the address into ten bits; the top eight bits fill a partial chunk.
    function automatic logic [9:0] lec_xor10(input logic [47:0] mac);
        logic [9:0] acc;
        acc = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30];
        acc = acc ^ {2'b00, mac[47:40]};
        return acc;
    endfunction

    assign req      = avm_req.read | avm_req.write;
    assign hit      = avm_req.address[11:2] == lec_pkg::LFC_OFFSET[11:2];
    assign hsel     = lec_pkg::lec_hash_t'(state_reg.cfg[lec_pkg::HASH_MSB:lec_pkg::HASH_LSB]);
    assign crc_idx  = lec_crc10(hash_req.dest_mac);
    assign xor_idx  = lec_xor10(hash_req.dest_mac);

    always_comb begin
        state_next           = state_reg;
        state_next.ack       = 1'b0;
        state_next.rvalid    = 1'b0;
        state_next.frame     = '0;
        state_next.age       = '0;
        state_next.hash      = '0;

        // Each access waits exactly one cycle, then completes on the acknowledge.
        // A write lands only at the edge that completes the access, when waitrequest is low.
        if (avm_req.write && state_reg.ack && hit && avm_req.byteenable[0]) begin
            state_next.cfg = avm_req.writedata[7:0];
        end

        if (req && !state_reg.ack) begin
            state_next.ack = 1'b1;
            if (avm_req.read) begin
                state_next.rvalid = 1'b1;
                // Unmapped words and the upper 24 bits read as zero.
                state_next.rdata  = hit ? {24'h000000, state_reg.cfg} : 32'h00000000;
            end
        end

        if (frame_req.valid) begin
            state_next.frame.valid = 1'b1;
            if (!state_reg.cfg[lec_pkg::VLAN_EN_BIT] || !frame_req.vid_invalid) begin
                state_next.frame.vid_action = lec_pkg::LEC_VID_PASS;
            end else if (frame_req.unknown_vid_fwd_en) begin
                state_next.frame.vid_action = lec_pkg::LEC_VID_UNKNOWN;
            end else if (state_reg.cfg[lec_pkg::DROP_VID_BIT]) begin
                state_next.frame.vid_action = lec_pkg::LEC_VID_DROP;
            end else begin
                state_next.frame.vid_action = lec_pkg::LEC_VID_HOST;
            end
            state_next.frame.rmc_hit = frame_req.rmc_match & state_reg.cfg[lec_pkg::RMC_EN_BIT];
        end

        if (entry_update) begin
            state_next.age.valid     = 1'b1;
            state_next.age.age_count = state_reg.cfg[lec_pkg::AGE_MSB:lec_pkg::AGE_LSB];
        end

        if (hash_req.valid) begin
            state_next.hash.valid = 1'b1;
            unique case (hsel)
                lec_pkg::LEC_HASH_CRC:    state_next.hash.index = crc_idx;
                lec_pkg::LEC_HASH_XOR:    state_next.hash.index = xor_idx;
                lec_pkg::LEC_HASH_DIRECT,
                lec_pkg::LEC_HASH_DIR2:   state_next.hash.index = hash_req.dest_mac[9:0];
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg       <= '0;
            state_reg.cfg   <= lec_pkg::LFC_RESET;
        end else begin
            state_reg       <= state_next;
        end
    end

    assign avm_waitrequest          = req & ~state_reg.ack;
    assign avm_readdata             = state_reg.rdata;
    assign avm_readdatavalid        = state_reg.rvalid;
    // VLAN mode is only meaningful once software has loaded the VLAN table.
    assign vlan_mode_en             = state_reg.cfg[lec_pkg::VLAN_EN_BIT];
    assign rmc_lookup_en            = state_reg.cfg[lec_pkg::RMC_EN_BIT];
    assign lookup_index_hash_select = hsel;
    assign frame_rsp                = state_reg.frame;
    assign entry_age                = state_reg.age;
    assign hash_rsp                 = state_reg.hash;

endmodule

// File: tb/lec_lookup_config_assertions.sv
// Port checker for the lookup engine control register.
// Assumes one clock, sys_clk, and a synchronous active-high rst.
`timescale 1ns/1ps
module lec_lookup_config_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire lec_pkg::lec_avm_req_t avm_req,
    input wire logic avm_waitrequest,
    input wire logic vlan_mode_en,
    input wire logic rmc_lookup_en,
    input wire lec_pkg::lec_hash_t lookup_index_hash_select,
    input wire lec_pkg::lec_frame_req_t frame_req,
    input wire lec_pkg::lec_frame_rsp_t frame_rsp,
    input wire logic entry_update,
    input wire lec_pkg::lec_age_rsp_t entry_age,
    input wire lec_pkg::lec_hash_req_t hash_req,
    input wire lec_pkg::lec_hash_rsp_t hash_rsp
);
    logic [9:0] mac_q;
    logic       hit_q;
    always_ff @(posedge sys_clk) begin
        mac_q <= hash_req.dest_mac[9:0];
        hit_q <= frame_req.rmc_match && rmc_lookup_en;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_wait; (avm_req.read || avm_req.write) && avm_waitrequest |=> !avm_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("access not answered");
    property p_rst; $past(rst) |-> !vlan_mode_en && !rmc_lookup_en; endproperty
    a_rst: assert property (p_rst) else $error("enable set after reset");
    property p_rsth; $past(rst) |-> lookup_index_hash_select == 2'h1; endproperty
    a_rsth: assert property (p_rsth) else $error("hash select reset wrong");
    property p_pass; frame_req.valid && !vlan_mode_en |=> frame_rsp.valid && frame_rsp.vid_action == 2'h0; endproperty
    a_pass: assert property (p_pass) else $error("frame not passed");
    property p_unk; frame_req.valid && vlan_mode_en && frame_req.vid_invalid && frame_req.unknown_vid_fwd_en
        |=> frame_rsp.vid_action == 2'h3; endproperty
    a_unk: assert property (p_unk) else $error("unknown handling lost");
    property p_rmc; frame_req.valid |=> frame_rsp.rmc_hit == hit_q; endproperty
    a_rmc: assert property (p_rmc) else $error("multicast hit wrong");
    property p_dir; hash_req.valid && lookup_index_hash_select inside {2'h0, 2'h3} |=> hash_rsp.index == mac_q; endproperty
    a_dir: assert property (p_dir) else $error("direct index wrong");
    property p_age; entry_update ##1 !entry_update |-> entry_age.valid ##1 !entry_age.valid; endproperty
    a_age: assert property (p_age) else $error("age load pulse wrong");
    cover property (frame_req.valid && vlan_mode_en && frame_req.vid_invalid);
    cover property (hash_req.valid && lookup_index_hash_select == 2'h2);
    cover property (avm_req.write && !avm_waitrequest);
endmodule
bind lec_lookup_config lec_lookup_config_checker u_chk (.*);

// File: tb/test_lec_lookup_config.sv
// Bench for the lookup engine control register over Avalon-MM.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module test_lec_lookup_config;
    logic sys_clk = 0, rst = 1, entry_update = 0;
    lec_pkg::lec_avm_req_t avm_req = '0;
    lec_pkg::lec_frame_req_t frame_req = '0;
    lec_pkg::lec_hash_req_t hash_req = '0;
    logic [31:0] avm_readdata, q;
    logic avm_readdatavalid, avm_waitrequest, vlan_mode_en, rmc_lookup_en;
    lec_pkg::lec_hash_t lookup_index_hash_select;
    lec_pkg::lec_frame_rsp_t frame_rsp;
    lec_pkg::lec_age_rsp_t entry_age;
    lec_pkg::lec_hash_rsp_t hash_rsp;
    int n_errors = 0, checks = 0;
    lec_lookup_config u_lec_lookup_config (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic be);
        int   n = 0;
        logic w;
        @(posedge sys_clk);
        avm_req <= '{read: !wr, write: wr, address: a, byteenable: {3'h0, be}, writedata: {24'h0, d}};
        // Waitrequest and read data are looked at mid-cycle, where they stand before the next rising edge.
        do begin
            @(negedge sys_clk);
            n++;
            w = avm_waitrequest;
            q = avm_readdata;
            if (!wr && w === 1'b0) chk(avm_readdatavalid, 1'b1);
            @(posedge sys_clk);
        end while (w !== 1'b0 && n < 20);
        avm_req <= '0;
        @(posedge sys_clk);
        if (n >= 20) begin
            n_errors++;
            report_and_stop;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b1);
        chk(q, {24'h0, e});
    endtask
    // Pulses all three request ports together; responses are read on return.
    task automatic fire(input lec_pkg::lec_frame_req_t f, input logic [47:0] m);
        frame_req <= f;
        hash_req <= '{valid: 1'b1, dest_mac: m};
        entry_update <= 1'b1;
        @(posedge sys_clk);
        frame_req <= '0;
        hash_req <= '0;
        entry_update <= 1'b0;
        // Responses stand for one cycle only; return mid-cycle so the caller judges them while they stand.
        @(negedge sys_clk);
    endtask
    task automatic t_regs;
        rd(lec_pkg::LFC_OFFSET, 8'h61);
        bus(1'b1, lec_pkg::LFC_OFFSET, 8'h9e, 1'b0);
        rd(lec_pkg::LFC_OFFSET, 8'h61);
        bus(1'b1, lec_pkg::LFC_OFFSET, 8'h9e, 1'b1);
        rd(lec_pkg::LFC_OFFSET, 8'h9e);
        chk({vlan_mode_en, rmc_lookup_en, lookup_index_hash_select}, 4'he);
        bus(1'b1, 12'h314, 8'h00, 1'b1);
        rd(12'h314, 8'h00);
        rd(lec_pkg::LFC_OFFSET, 8'h9e);
    endtask
    task automatic t_frames;
        logic [1:0] act;
        for (int i = 0; i < 32; i++) begin
            bus(1'b1, lec_pkg::LFC_OFFSET, {i[0], i[1], i[4:2], i[4], 2'b01}, 1'b1);
            fire('{valid: 1'b1, vid_invalid: i[2], unknown_vid_fwd_en: i[3], rmc_match: i[1]}, 48'h0);
            act = (!i[0] || !i[2]) ? 2'h0 : i[3] ? 2'h3 : i[1] ? 2'h1 : 2'h2;
            chk(frame_rsp, {1'b1, act, i[4] & i[1]});
            chk(entry_age, {1'b1, i[4:2]});
        end
    endtask
    task automatic t_hash;
        logic [47:0] m = 48'ha5c3_96f0_1e2d;
        logic [9:0]  c = 10'h3ff;
        logic [9:0]  e[4];
        for (int i = 47; i >= 0; i--)
            c = {c[8:0], 1'b0} ^ ((c[9] ^ m[i]) ? lec_pkg::CRC_POLY : 10'h0);
        e = '{m[9:0], c, m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'h0, m[47:40]}, m[9:0]};
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, lec_pkg::LFC_OFFSET, {6'h18, s[1:0]}, 1'b1);
            fire('0, m);
            chk(hash_rsp, {1'b1, e[s]});
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs;
        t_frames;
        t_hash;
        report_and_stop;
    end
endmodule
